/* verilog/fpd_pkg.sv */
// fpd_pkg.sv: shared constants and types of the front panel driver
// assumes a 25 MHz system clock and a serial link clocked by the controller
//
// Contract
// RQ1: power-up lights all lamps and all segments
// RQ2: first received content replaces the test pattern
// RQ3: controller shifts serial data with 750 kHz clock; fpd_ctrl_model shifts with a 15 ns link clock period
// RQ4: serial bits captured in two shift registers
// RQ5: controller finishes shifting before display strobe
// RQ6: display strobe fires one-shot raising processor interrupt
// RQ7: reading the data resets the one-shot
// RQ8: exactly one character driven at any time; char_en_q stays all zero from reset until the first refresh strobe
// RQ9: latched character address decoded to one enable
// RQ10: segments latched into seven or fourteen-segment latches
// RQ11: each character enabled about 640 microseconds
// RQ12: indicator lamps lit by low outputs
// RQ13: lamp states travel in the display payload
// RQ14: quadrature wheel inputs squared, raise motion interrupt
// RQ15: wheel interrupt active high, separate direction line
// RQ16: controller answers wheel interrupts with new content
// RQ17: keys form eight columns by four rows
// RQ18: column pattern shifted in, latched on key strobe
// RQ19: columns driven, rows passed back unaltered
// RQ20: write low and decoder strobes every dwell period
// RQ21: processor interrupt is 50 microsecond low pulse
// RQ22: processor clock 6 MHz, address strobe 60-40
// RQ23: controller clears wheel interrupt by reset line
// RQ24: direction from leading phase, held during interrupt
// RQ25: two eight-bit registers, rising edge, sixteen bits

package fpd_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int DWELL_US = 640;
  localparam int DWELL_CYC = DWELL_US * CLK_MHZ;
  localparam int IRQ_US = 50;
  localparam int IRQ_CYC = IRQ_US * CLK_MHZ;
  localparam int OS_W = $clog2(IRQ_CYC);
  localparam int PROC_KHZ = 6000;
  localparam int ALE_DIV = 15;
  localparam int ALE_CYC = CLK_MHZ * 1000 * ALE_DIV / PROC_KHZ;
  localparam int ALE_HI_PCT = 60;
  localparam int ALE_HI_CYC = ALE_CYC * ALE_HI_PCT / 100;
  localparam int ALE_W = $clog2(ALE_CYC);
  localparam int WR_CYC = 2;
  localparam int FILT_CYC = 8;
  localparam int FILT_W = $clog2(FILT_CYC);

  // ---------------------------------------------------------------
  // sizes and payload layout
  // ---------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int WORD_W = 2 * BYTE_W;
  localparam int NCOL = 8;
  localparam int NROW = 4;
  localparam int NLED = 8;
  localparam int ADDR_W = 5;
  localparam int NCHAR = 32;
  localparam int SEG_W = 7;
  localparam int KIND_BIT = 15;
  localparam int POS_LSB = 10;
  localparam int HALF_BIT = 8;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [NLED-1:0] LED_ALL_ON = 8'h00;
  localparam logic [SEG_W-1:0] SEG_ALL = 7'h7F;
  localparam logic [NCOL-1:0] COL_RST = 8'h00;

  typedef enum logic [1:0] {
    SCAN_FETCH,
    SCAN_SHOW,
    SCAN_DWELL
  } fpd_scan_t;

endpackage : fpd_pkg

/* verilog/fpd_link_shift.sv */
// fpd_link_shift.sv: serial capture registers on the link clock
// assumes the controller clock stands still between transfers
`timescale 1ns/1ps
module fpd_link_shift (
  // link
  input wire logic link_clock,
  input wire logic serial_data,
  // captured bits, newest in bit 0
  output logic [fpd_pkg::WORD_W-1:0] shift_q
);

  logic [fpd_pkg::BYTE_W-1:0] first_q;
  logic [fpd_pkg::BYTE_W-1:0] second_q;

  // two cascaded bytes; no reset because the clock may never run
  always_ff @(posedge link_clock) begin // see RQ3 see RQ25
    first_q <= {first_q[fpd_pkg::BYTE_W-2:0], serial_data};
    second_q <= {second_q[fpd_pkg::BYTE_W-2:0],
                 first_q[fpd_pkg::BYTE_W-1]};
  end

  assign shift_q = {second_q, first_q}; // see RQ4

endmodule : fpd_link_shift

/* verilog/fpd_seg_mem.sv */
// fpd_seg_mem.sv: segment pattern store, one entry per character
// assumes one writer and one reader on the system clock
`timescale 1ns/1ps
module fpd_seg_mem (
  // system
  input wire logic clock,
  input wire logic ce,
  // write side, one enable per half pattern
  input wire logic [fpd_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [1:0] wr_half,
  input wire logic [fpd_pkg::SEG_W-1:0] wr_data,
  // read side
  input wire logic [fpd_pkg::ADDR_W-1:0] rd_addr,
  output logic [2*fpd_pkg::SEG_W-1:0] rd_data_q
);

  logic [fpd_pkg::SEG_W-1:0] lo_mem [fpd_pkg::NCHAR];
  logic [fpd_pkg::SEG_W-1:0] hi_mem [fpd_pkg::NCHAR];

  always_ff @(posedge clock) begin
    if (ce) begin
      if (wr_half[0]) begin
        lo_mem[wr_addr] <= wr_data;
      end
      if (wr_half[1]) begin
        hi_mem[wr_addr] <= wr_data;
      end
      rd_data_q <= {hi_mem[rd_addr], lo_mem[rd_addr]};
    end
  end

endmodule : fpd_seg_mem

/* verilog/fpd_top.sv */
// fpd_top.sv: front panel driver, display refresh, wheel and keys
// assumes controller pins are asynchronous to clock and that the
// controller has stopped shifting before it raises a strobe
`timescale 1ns/1ps
module fpd_top #(
  parameter int DWELL_CYC = fpd_pkg::DWELL_CYC
) (
  // system
  input wire logic clock,
  input wire logic ce,
  input wire logic srst,
  // serial link from the controller
  input wire logic link_clock,
  input wire logic serial_data,
  input wire logic display_load_strobe,
  input wire logic key_matrix_latch_strobe,
  input wire logic wheel_irq_clear,
  // tuning wheel
  input wire logic wheel_phase_a,
  input wire logic wheel_phase_b,
  output logic wheel_motion_irq,
  output logic wheel_dir,
  // key matrix
  output logic [fpd_pkg::NCOL-1:0] col_drive_q,
  input wire logic [fpd_pkg::NROW-1:0] matrix_row_in,
  output logic [fpd_pkg::NROW-1:0] matrix_row_return,
  // character displays and lamps
  output logic [fpd_pkg::NCHAR-1:0] char_en_q,
  output logic [fpd_pkg::ADDR_W-1:0] char_addr_q,
  output logic [1:0] dec_strobe_q,
  output logic write_n_q,
  output logic [fpd_pkg::SEG_W-1:0] seg7_q,
  output logic [2*fpd_pkg::SEG_W-1:0] seg14_q,
  output logic [fpd_pkg::NLED-1:0] led_n_q,
  // local processor observation
  output logic disp_irq_n,
  output logic ale_q
);

  localparam int AW = fpd_pkg::ADDR_W;
  localparam int SW = fpd_pkg::SEG_W;
  localparam int OW = fpd_pkg::OS_W;
  localparam int DW_W = $clog2(DWELL_CYC + 1);

  function automatic logic [fpd_pkg::NCHAR-1:0] onehot(
    input logic [fpd_pkg::ADDR_W-1:0] a
  );
    onehot = '0;
    onehot[a] = 1'b1;
  endfunction : onehot

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic [1:0] sync3_q;
  wire [NSYNC-1:0] pins = {wheel_phase_b, wheel_phase_a, wheel_irq_clear,
                           key_matrix_latch_strobe, display_load_strobe};

  always_ff @(posedge clock) begin
    if (srst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else if (ce) begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q[1:0];
    end
  end

  wire disp_stb_rise = sync2_q[0] & ~sync3_q[0];
  wire key_stb_rise = sync2_q[1] & ~sync3_q[1];
  wire clr_lvl = sync2_q[2];
  wire [1:0] ph_raw = sync2_q[4:3];

  // ---------------------------------------------------------------
  // serial capture on the link clock
  // ---------------------------------------------------------------
  logic [fpd_pkg::WORD_W-1:0] link_word;

  fpd_link_shift u_link (
    .link_clock(link_clock),
    .serial_data(serial_data),
    .shift_q(link_word)
  );

  // ---------------------------------------------------------------
  // display load one-shot and read
  // ---------------------------------------------------------------
  // link_word is quasi-static once a strobe arrives, so it is sampled
  // only on the synchronised strobe edge
  logic [fpd_pkg::WORD_W-1:0] word_q;
  logic os_q;
  logic [OW-1:0] os_cnt_q;
  wire read_fire = os_q && (os_cnt_q == OW'(fpd_pkg::IRQ_CYC - 1));

  always_ff @(posedge clock) begin
    if (srst) begin
      os_q <= 1'b0;
      os_cnt_q <= '0;
      word_q <= '0;
    end else if (ce) begin
      if (disp_stb_rise) begin // see RQ5 see RQ6
        os_q <= 1'b1;
        os_cnt_q <= '0;
        word_q <= link_word; // see RQ4
      end else if (read_fire) begin
        os_q <= 1'b0; // see RQ7
        os_cnt_q <= '0;
      end else if (os_q) begin
        os_cnt_q <= os_cnt_q + 1'b1; // see RQ21
      end
    end
  end

  assign disp_irq_n = ~os_q; // see RQ21

  // ---------------------------------------------------------------
  // payload decode: lamp word or half a character pattern
  // ---------------------------------------------------------------
  wire is_led = word_q[fpd_pkg::KIND_BIT]; // see RQ13
  wire [AW-1:0] wr_pos = word_q[fpd_pkg::POS_LSB +: AW];
  wire wr_hi = word_q[fpd_pkg::HALF_BIT] & wr_pos[AW-1];
  wire [1:0] wr_half = (read_fire && !is_led) ? {wr_hi, ~wr_hi} : 2'h0;
  wire [SW-1:0] wr_seg = word_q[SW-1:0];

  logic test_q;
  logic [fpd_pkg::NCHAR-1:0] vld_lo_q;
  logic [fpd_pkg::NCHAR-1:0] vld_hi_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      test_q <= 1'b1; // see RQ1
      led_n_q <= fpd_pkg::LED_ALL_ON; // see RQ1
      vld_lo_q <= '0;
      vld_hi_q <= '0;
    end else if (ce && read_fire) begin
      test_q <= 1'b0; // see RQ2
      if (is_led) begin
        led_n_q <= ~word_q[fpd_pkg::NLED-1:0]; // see RQ12
      end
      if (wr_half[0]) begin
        vld_lo_q <= vld_lo_q | onehot(wr_pos);
      end
      if (wr_half[1]) begin
        vld_hi_q <= vld_hi_q | onehot(wr_pos);
      end
    end
  end

  // ---------------------------------------------------------------
  // multiplexed refresh
  // ---------------------------------------------------------------
  fpd_pkg::fpd_scan_t scan_q;
  fpd_pkg::fpd_scan_t scan_d;
  logic [AW-1:0] scan_addr_q;
  logic [DW_W-1:0] dwell_cnt_q;
  logic [2*SW-1:0] mem_rd;

  fpd_seg_mem u_mem (
    .clock(clock),
    .ce(ce),
    .wr_addr(wr_pos),
    .wr_half(wr_half),
    .wr_data(wr_seg),
    .rd_addr(scan_addr_q),
    .rd_data_q(mem_rd)
  );

  wire show = scan_q == fpd_pkg::SCAN_SHOW;
  wire dwell = scan_q == fpd_pkg::SCAN_DWELL;
  wire dwell_done = dwell_cnt_q == DW_W'(DWELL_CYC - 3);
  wire alnum = scan_addr_q[AW-1];
  wire vlo = vld_lo_q[scan_addr_q];
  wire vhi = vld_hi_q[scan_addr_q];
  // unwritten positions stay blank instead of showing stale memory
  wire [SW-1:0] lo_pat = test_q ? fpd_pkg::SEG_ALL :
                         (vlo ? mem_rd[SW-1:0] : '0);
  wire [SW-1:0] hi_pat = test_q ? fpd_pkg::SEG_ALL :
                         (vhi ? mem_rd[2*SW-1:SW] : '0);
  wire wr_low = show || (dwell && dwell_cnt_q < DW_W'(fpd_pkg::WR_CYC - 1));

  always_comb begin
    scan_d = scan_q;
    case (scan_q)
      fpd_pkg::SCAN_FETCH: begin
        scan_d = fpd_pkg::SCAN_SHOW;
      end
      fpd_pkg::SCAN_SHOW: begin
        scan_d = fpd_pkg::SCAN_DWELL;
      end
      fpd_pkg::SCAN_DWELL: begin
        if (dwell_done) begin // see RQ11
          scan_d = fpd_pkg::SCAN_FETCH;
        end
      end
      default: begin
        scan_d = fpd_pkg::SCAN_FETCH;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      scan_q <= fpd_pkg::SCAN_FETCH;
      scan_addr_q <= '0;
      dwell_cnt_q <= '0;
    end else if (ce) begin
      scan_q <= scan_d;
      dwell_cnt_q <= dwell ? dwell_cnt_q + 1'b1 : '0;
      if (dwell && dwell_done) begin
        scan_addr_q <= scan_addr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      char_en_q <= '0;
      char_addr_q <= '0;
      dec_strobe_q <= 2'h0;
      write_n_q <= 1'b1;
      seg7_q <= '0;
      seg14_q <= '0;
    end else if (ce) begin
      dec_strobe_q <= {2{show}}; // see RQ20
      write_n_q <= ~wr_low; // see RQ20
      if (show) begin
        char_addr_q <= scan_addr_q; // see RQ9
        char_en_q <= onehot(scan_addr_q); // see RQ8 see RQ9
        if (alnum) begin
          seg14_q <= {hi_pat, lo_pat}; // see RQ10
        end else begin
          seg7_q <= lo_pat; // see RQ10
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // tuning wheel
  // ---------------------------------------------------------------
  // a phase only changes after FILT_CYC agreeing samples, which stands
  // in for the hysteresis of a Schmitt input
  logic [1:0] ph_q;
  logic a_prev_q;
  logic wheel_irq_q;
  logic wheel_dir_q;

  for (genvar i = 0; i < 2; i++) begin : g_square
    logic [fpd_pkg::FILT_W-1:0] flt_q;
    wire differs = ph_raw[i] != ph_q[i];
    always_ff @(posedge clock) begin
      if (srst) begin
        flt_q <= '0;
        ph_q[i] <= 1'b0;
      end else if (ce) begin
        if (!differs) begin
          flt_q <= '0;
        end else if (flt_q == fpd_pkg::FILT_W'(fpd_pkg::FILT_CYC - 1)) begin
          flt_q <= '0;
          ph_q[i] <= ph_raw[i]; // see RQ14
        end else begin
          flt_q <= flt_q + 1'b1;
        end
      end
    end
  end

  wire a_rise = ph_q[0] & ~a_prev_q;
  wire dir_take = a_rise & (~wheel_irq_q | clr_lvl);

  always_ff @(posedge clock) begin
    if (srst) begin
      a_prev_q <= 1'b0;
      wheel_irq_q <= 1'b0;
      wheel_dir_q <= 1'b0;
    end else if (ce) begin
      a_prev_q <= ph_q[0];
      // a new edge wins over a clear in the same cycle
      wheel_irq_q <= a_rise | (wheel_irq_q & ~clr_lvl); // see RQ14 see RQ23
      if (dir_take) begin
        wheel_dir_q <= ~ph_q[1]; // see RQ24
      end
    end
  end

  assign wheel_motion_irq = wheel_irq_q; // see RQ15
  assign wheel_dir = wheel_dir_q; // see RQ15

  // ---------------------------------------------------------------
  // key matrix
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      col_drive_q <= fpd_pkg::COL_RST;
    end else if (ce && key_stb_rise) begin
      col_drive_q <= link_word[fpd_pkg::NCOL-1:0]; // see RQ17 see RQ18
    end
  end

  assign matrix_row_return = matrix_row_in; // see RQ19

  // ---------------------------------------------------------------
  // processor address strobe
  // ---------------------------------------------------------------
  logic [fpd_pkg::ALE_W-1:0] ale_cnt_q;
  wire ale_wrap = ale_cnt_q == fpd_pkg::ALE_W'(fpd_pkg::ALE_CYC - 1);

  always_ff @(posedge clock) begin
    if (srst) begin
      ale_cnt_q <= '0;
      ale_q <= 1'b0;
    end else if (ce) begin
      ale_cnt_q <= ale_wrap ? '0 : ale_cnt_q + 1'b1;
      ale_q <= ale_cnt_q < fpd_pkg::ALE_W'(fpd_pkg::ALE_HI_CYC); // see RQ22
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  localparam int IRQ_LAST = fpd_pkg::IRQ_CYC - 1;
  logic [DW_W-1:0] gap_q;
  logic seen_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end else if (ce) begin
      seen_q <= seen_q | dec_strobe_q[0];
      gap_q <= dec_strobe_q[0] ? '0 : gap_q + 1'b1;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (srst || !ce);

  a_test_all_on: assert property (test_q && show |=> // see RQ1
    (char_addr_q[AW-1] ? &seg14_q : &seg7_q) && led_n_q == '0)
    else $error("test pattern not fully lit");
  a_test_ends: assert property (read_fire |=> !test_q) // see RQ2
    else $error("test pattern kept after content");
  a_irq_on_strobe: assert property (disp_stb_rise |=> !disp_irq_n) // see RQ6
    else $error("strobe did not raise interrupt");
  a_read_clears: assert property ( // see RQ7
    read_fire && !disp_stb_rise |=> disp_irq_n && !os_q)
    else $error("read did not clear one-shot");
  a_irq_start: assert property ($rose(os_q) |-> os_cnt_q == '0) // see RQ21
    else $error("interrupt count not restarted");
  a_irq_width: assert property ( // see RQ21
    $fell(os_q) |-> $past(os_cnt_q) == OW'(IRQ_LAST))
    else $error("interrupt pulse width wrong");
  a_one_char: assert property ($onehot0(char_en_q)) // see RQ8
    else $error("more than one character enabled");
  a_dec_match: assert property (dec_strobe_q[0] |-> // see RQ9
    dec_strobe_q[1] && char_en_q == onehot(char_addr_q))
    else $error("enable does not match address");
  a_char_period: assert property ( // see RQ11
    dec_strobe_q[0] && seen_q |-> gap_q == DW_W'(DWELL_CYC - 1))
    else $error("character dwell period wrong");
  a_write_pulse: assert property ( // see RQ20
    dec_strobe_q[0] |-> !write_n_q [*2] ##1 write_n_q)
    else $error("write pulse shape wrong");
  a_wheel_set: assert property (a_rise |=> wheel_motion_irq) // see RQ15
    else $error("wheel edge lost");
  a_dir_hold: assert property ( // see RQ24
    wheel_irq_q && $past(wheel_irq_q) && !$past(clr_lvl)
    |-> $stable(wheel_dir))
    else $error("direction moved while pending");

  c_char_word: cover property (read_fire && !is_led);
  c_led_word: cover property (read_fire && is_led);
  c_wheel: cover property (a_rise ##[1:50] clr_lvl);
  c_key_latch: cover property (key_stb_rise);

endmodule : fpd_top

/* bench/fpd_ctrl_model.sv */
// fpd_ctrl_model.sv: behavioural controller on the far side of the link
// assumes the bench calls its tasks just after a system clock edge
`timescale 1ns/1ps
module fpd_ctrl_model #(
  parameter real HALF_NS = 7.5
) (
  // link toward the driver
  output logic link_clock,
  output logic serial_data,
  // strobes and wheel service
  output logic display_load_strobe,
  output logic key_matrix_latch_strobe,
  output logic wheel_irq_clear
);
  initial begin
    link_clock = 1'b0;
    serial_data = 1'b1;
    display_load_strobe = 1'b0;
    key_matrix_latch_strobe = 1'b0;
    wheel_irq_clear = 1'b0;
  end

  // ---------------------------------------------------------------
  // serial shifting, clock only runs inside a frame
  // ---------------------------------------------------------------
  task automatic shift_bit(input logic b);
    serial_data = b;
    #(HALF_NS) link_clock = 1'b1;
    #(HALF_NS) link_clock = 1'b0;
  endtask : shift_bit

  // msb first, so the last bit lands in bit 0
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) shift_bit(w[i]);
    // released line: show the inverse rather than a stale value
    serial_data = ~serial_data;
  endtask : send_word

  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) shift_bit(b[i]);
    serial_data = ~serial_data;
  endtask : send_byte

  // ---------------------------------------------------------------
  // strobes, raised only after a whole payload was shifted
  // ---------------------------------------------------------------
  task automatic set_disp(input logic lvl);
    display_load_strobe = lvl;
  endtask : set_disp

  task automatic set_keys(input logic lvl);
    key_matrix_latch_strobe = lvl;
  endtask : set_keys

  task automatic pulse_clear();
    wheel_irq_clear = 1'b1;
    #400 wheel_irq_clear = 1'b0;
  endtask : pulse_clear
endmodule : fpd_ctrl_model

/* bench/tb_front_panel_display_keyboard_driver.sv */
// tb_front_panel_display_keyboard_driver.sv: self-checking bench
// assumes the design package and fpd_top, driven by fpd_ctrl_model
`timescale 1ns/1ps
module tb_front_panel_display_keyboard_driver;
  localparam int DWELL = 20;
  localparam int LIMIT = 20000;
  localparam int SCAN = 32 * DWELL + 10;
  logic clock, ce, srst, link_clock, serial_data;
  logic display_load_strobe, key_matrix_latch_strobe, wheel_irq_clear;
  logic wheel_phase_a, wheel_phase_b, wheel_motion_irq, wheel_dir;
  logic [fpd_pkg::NCOL-1:0] col_drive_q;
  logic [fpd_pkg::NROW-1:0] matrix_row_in, matrix_row_return;
  logic [fpd_pkg::NCHAR-1:0] char_en_q;
  logic [fpd_pkg::ADDR_W-1:0] char_addr_q;
  logic [1:0] dec_strobe_q;
  logic write_n_q, disp_irq_n, ale_q;
  logic [fpd_pkg::SEG_W-1:0] seg7_q;
  logic [2*fpd_pkg::SEG_W-1:0] seg14_q;
  logic [fpd_pkg::NLED-1:0] led_n_q;
  int num_errors, tests_run, cycle_cnt, n;

  fpd_top #(.DWELL_CYC(DWELL)) dut (
    .clock(clock), .ce(ce), .srst(srst),
    .link_clock(link_clock), .serial_data(serial_data),
    .display_load_strobe(display_load_strobe),
    .key_matrix_latch_strobe(key_matrix_latch_strobe),
    .wheel_irq_clear(wheel_irq_clear),
    .wheel_phase_a(wheel_phase_a), .wheel_phase_b(wheel_phase_b),
    .wheel_motion_irq(wheel_motion_irq), .wheel_dir(wheel_dir),
    .col_drive_q(col_drive_q), .matrix_row_in(matrix_row_in),
    .matrix_row_return(matrix_row_return), .char_en_q(char_en_q),
    .char_addr_q(char_addr_q), .dec_strobe_q(dec_strobe_q),
    .write_n_q(write_n_q), .seg7_q(seg7_q), .seg14_q(seg14_q),
    .led_n_q(led_n_q), .disp_irq_n(disp_irq_n), .ale_q(ale_q)
  );

  fpd_ctrl_model u_ctrl (
    .link_clock(link_clock), .serial_data(serial_data),
    .display_load_strobe(display_load_strobe),
    .key_matrix_latch_strobe(key_matrix_latch_strobe),
    .wheel_irq_clear(wheel_irq_clear)
  );

  initial clock = 1'b0;
  always #20 clock = ~clock;

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick

  task automatic check_val(input logic [31:0] seen, input logic [31:0] exp,
                           input string what);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask : check_val

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  always @(posedge clock) begin
    cycle_cnt++;
    if (cycle_cnt == LIMIT) begin
      num_errors++;
      give_verdict();
    end
  end

  // stops on the cycle whose refresh strobe shows address a
  task automatic wait_char(input logic [4:0] a);
    for (n = 0; n < SCAN && !(dec_strobe_q === 2'b11 && char_addr_q === a);
         n++) tick();
    check_val(char_addr_q, a, "refresh never reached");
  endtask : wait_char

  // one whole transfer: shift, strobe, then the interrupt window
  task automatic disp_word(input logic [15:0] w);
    u_ctrl.send_word(w);
    u_ctrl.set_disp(1'b1);
    for (n = 0; n < 10 && disp_irq_n !== 1'b0; n++) tick();
    check_val(disp_irq_n, 1'b0, "no display interrupt");
    u_ctrl.set_disp(1'b0);
    for (n = 0; n < 2000 && disp_irq_n === 1'b0; n++) tick();
    check_val(n, fpd_pkg::IRQ_CYC, "interrupt width");
  endtask : disp_word

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_power_up();
    check_val(led_n_q, 8'h00, "lamps not lit");
    check_val(disp_irq_n, 1'b1, "irq at reset");
    check_val(wheel_motion_irq, 1'b0, "wheel irq at reset");
    wait_char(5'h00);
    check_val(seg7_q, 7'h7F, "numeric test pattern");
    wait_char(5'h10);
    check_val(seg14_q, 14'h3FFF, "alnum test pattern");
    $display("test power_up done");
  endtask : test_power_up

  task automatic test_refresh();
    wait_char(5'h05);
    check_val(char_en_q, 32'h20, "enable not one-hot");
    check_val(write_n_q, 1'b0, "write low missing");
    tick();
    check_val(dec_strobe_q, 2'b00, "strobe too long");
    check_val(write_n_q, 1'b0, "write pulse short");
    tick();
    check_val(write_n_q, 1'b1, "write pulse long");
    check_val(char_en_q, 32'h20, "enable not held");
    for (n = 2; n < 100 && dec_strobe_q !== 2'b11; n++) tick();
    check_val(n, DWELL, "dwell period");
    check_val(char_addr_q, 5'h06, "next address");
    check_val(char_en_q, 32'h40, "next enable");
    $display("test refresh done");
  endtask : test_refresh

  // ce low in the middle of an update must freeze the strobe and pulse
  task automatic test_hold();
    wait_char(5'h08);
    ce = 1'b0;
    repeat (30) tick();
    check_val(dec_strobe_q, 2'b11, "strobe not frozen");
    check_val(char_en_q, 32'h100, "enable not frozen");
    ce = 1'b1;
    tick();
    check_val(dec_strobe_q, 2'b00, "strobe after resume");
    check_val(write_n_q, 1'b0, "write after resume");
    $display("test hold done");
  endtask : test_hold

  task automatic test_ale();
    for (n = 0; n < 200 && ale_q !== 1'b0; n++) tick();
    for (n = 0; n < 200 && ale_q !== 1'b1; n++) tick();
    for (n = 0; n < 200 && ale_q === 1'b1; n++) tick();
    check_val(n, fpd_pkg::ALE_HI_CYC, "ale high time");
    for (n = 0; n < 200 && ale_q === 1'b0; n++) tick();
    check_val(n, fpd_pkg::ALE_CYC - fpd_pkg::ALE_HI_CYC, "ale low");
    $display("test ale done");
  endtask : test_ale

  task automatic test_display();
    disp_word({1'b0, 5'd3, 3'b000, 7'h55});
    wait_char(5'h03);
    check_val(seg7_q, 7'h55, "numeric content");
    wait_char(5'h04);
    check_val(seg7_q, 7'h00, "test pattern kept");
    disp_word({1'b0, 5'd20, 3'b000, 7'h2A});
    disp_word({1'b0, 5'd20, 3'b010, 7'h15});
    wait_char(5'h14);
    check_val(seg14_q, {7'h15, 7'h2A}, "alnum halves");
    disp_word({1'b1, 7'h00, 8'hA5});
    check_val(led_n_q, 8'h5A, "lamp word");
    $display("test display done");
  endtask : test_display

  task automatic test_keys();
    u_ctrl.send_byte(8'hC3);
    u_ctrl.set_keys(1'b1);
    for (n = 0; n < 10 && col_drive_q !== 8'hC3; n++) tick();
    check_val(col_drive_q, 8'hC3, "column latch");
    u_ctrl.set_keys(1'b0);
    u_ctrl.send_byte(8'h3C);
    repeat (10) tick();
    check_val(col_drive_q, 8'hC3, "latched without strobe");
    for (int r = 0; r < 16; r++) begin
      matrix_row_in = r[3:0];
      tick();
      check_val(matrix_row_return, r[3:0], "row return");
    end
    $display("test keys done");
  endtask : test_keys

  task automatic test_wheel();
    wheel_phase_a = 1'b1;
    for (n = 0; n < 30 && wheel_motion_irq !== 1'b1; n++) tick();
    check_val(wheel_motion_irq, 1'b1, "wheel irq");
    check_val(wheel_dir, 1'b1, "a leads");
    wheel_phase_b = 1'b1;
    repeat (15) tick();
    wheel_phase_a = 1'b0;
    repeat (15) tick();
    wheel_phase_a = 1'b1;
    repeat (15) tick();
    check_val(wheel_dir, 1'b1, "direction not held");
    check_val(wheel_motion_irq, 1'b1, "irq dropped");
    u_ctrl.pulse_clear();
    repeat (6) tick();
    check_val(wheel_motion_irq, 1'b0, "irq not cleared");
    wheel_phase_a = 1'b0;
    repeat (15) tick();
    wheel_phase_a = 1'b1;
    for (n = 0; n < 30 && wheel_motion_irq !== 1'b1; n++) tick();
    check_val(wheel_dir, 1'b0, "b leads");
    u_ctrl.pulse_clear();
    $display("test wheel done");
  endtask : test_wheel

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    num_errors = 0;
    tests_run = 0;
    cycle_cnt = 0;
    ce = 1'b1;
    srst = 1'b1;
    wheel_phase_a = 1'b0;
    wheel_phase_b = 1'b0;
    matrix_row_in = 4'h0;
    repeat (5) @(posedge clock);
    #1 srst = 1'b0;
    tick();
    test_power_up();
    test_refresh();
    test_hold();
    test_ale();
    test_display();
    test_keys();
    test_wheel();
    give_verdict();
  end
endmodule : tb_front_panel_display_keyboard_driver
